// ==== src/pwr_mode_consts.vh ====
/*
 * Constants for the power-mode and wake-up controller: mode codes,
 * wake-up delays, pin count.
 * Assumes inclusion by bare name from the controller source.
 */
`ifndef PWR_MODE_CONSTS_VH
`define PWR_MODE_CONSTS_VH

`define MODE_RUN          2'h0
`define MODE_SAVE         2'h1
`define MODE_DOWN         2'h2
`define MODE_WAKE         2'h3
`define WAKE_NORMAL_CYC   12'h800
`define WAKE_FAST_CYC     12'h020
`define WAKE_CNT_W        12
`define PIN_COUNT         8
`define CMP_EN_BIT        7
`define CMP_WAKE_BIT      6
`define FAST_WAKE_BIT     5
`define WDOG_EN_BIT       1

`endif

// ==== src/power_mode_wakeup_controller.v ====
/*
 * Power-mode and wake-up controller: run, power-save and power-down
 * states, clock/oscillator/program-memory gating, wake-up detection
 * and a wake-up delay counted in slow oscillator cycles.
 * Assumes the slow oscillator tick and all pins are asynchronous
 * and synchronised here; core stop requests and timer match flags
 * come from logic on CLK.
 */
`timescale 1ns/1ns
`include "pwr_mode_consts.vh"

module power_mode_wakeup_controller #(
  parameter PINS = `PIN_COUNT
) (
  input  wire            CLK,               // System clock, 250 MHz
  input  wire            RSTN,              // Async reset, active low
  input  wire            STOP_SAVE,         // Core issues power-save stop (pulse)
  input  wire            STOP_DOWN,         // Core issues power-down stop (pulse)
  input  wire            SLOW_OSC_TICK,     // Slow oscillator clock level (async)
  input  wire            FAST_OSC_EN_CFG,   // Software fast oscillator enable
  input  wire            SLOW_OSC_EN_CFG,   // Software slow oscillator enable
  input  wire [7:0]      CLOCK_MODE,        // Clock mode register image
  input  wire [7:0]      COMPARATOR_CONTROL, // Comparator control register image
  input  wire [7:0]      COMPARATOR_SELECT, // Comparator select register image
  input  wire [7:0]      MISC_CFG,          // Misc register image (bit 5 fast wake)
  input  wire            SLOW_BOOT,         // Slow boot-up configuration
  input  wire            CMP_OUT_EVT,       // Comparator wake event (async)
  input  wire            T16_MATCH,         // Sixteen-bit timer reached target
  input  wire            T16_SYSTEM_CLOCK_SOURCE_SRC,    // Sixteen-bit timer on system clock
  input  wire            T16_SRC_ON,        // Its source oscillator running
  input  wire            T8_MATCH,          // Eight-bit timer reached target
  input  wire            T8_SYSTEM_CLOCK_SOURCE_SRC,     // Eight-bit timer on system clock
  input  wire            T8_SRC_ON,         // Its source oscillator running
  input  wire [PINS-1:0] PIN_IN,            // Port A pin levels (async)
  input  wire [PINS-1:0] PIN_INPUT_MODE,    // Per-pin input mode
  input  wire [PINS-1:0] PIN_DIG_EN,        // Per-pin digital-input enable
  output reg             SYS_CLK_EN,        // System clock to core enabled
  output reg             FAST_OSC_EN,       // Fast internal oscillator enable
  output reg             SLOW_OSC_EN,       // Slow internal oscillator enable
  output reg             PROG_MEM_EN,       // Program memory powered
  output reg             T16_COUNT_EN,      // Sixteen-bit timer may count
  output reg             T8_COUNT_EN,       // Eight-bit timer may count
  output reg             WDOG_EN,           // Watchdog running
  output reg             CORE_RESUME,       // Core continues past stop (pulse)
  output reg  [1:0]      POWER_STATE        // Current state code
);

  localparam [1:0] RUN  = `MODE_RUN;
  localparam [1:0] SAVE = `MODE_SAVE;
  localparam [1:0] DOWN = `MODE_DOWN;
  localparam [1:0] WAKE = `MODE_WAKE;

  reg [1:0]             state_r;
  reg [1:0]             state_nxt;
  reg                   from_down_r;
  reg [PINS-1:0]        pin_s1_r;
  reg [PINS-1:0]        pin_s2_r;
  reg [PINS-1:0]        pin_ref_r;
  reg [2:0]             tick_s_r;
  reg [1:0]             cmp_s_r;
  reg [`WAKE_CNT_W-1:0] wcnt_r;
  reg [`WAKE_CNT_W-1:0] wtarget_r;
  wire                  tick_rise;
  wire [PINS-1:0]       pin_armed;
  wire                  pin_wake;
  wire                  t16_wake;
  wire                  t8_wake;
  wire                  cmp_wake;
  wire                  wake_evt;
  wire                  fast_sel;

  // Synchronisers; first stages read only by second stages
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_r <= {PINS{1'b0}};
      pin_s2_r <= {PINS{1'b0}};
      tick_s_r <= 3'h0;
      cmp_s_r  <= 2'h0;
    end else begin
      pin_s1_r <= PIN_IN;
      pin_s2_r <= pin_s1_r;
      tick_s_r <= {tick_s_r[1:0], SLOW_OSC_TICK};
      cmp_s_r  <= {cmp_s_r[0], CMP_OUT_EVT};
    end
  end

  assign tick_rise = tick_s_r[1] & ~tick_s_r[2];

  // Enabled pins per state
  assign pin_armed = (state_r == DOWN) ? PIN_DIG_EN
                                       : (PIN_DIG_EN & PIN_INPUT_MODE);
  assign pin_wake  = |(pin_armed & (pin_s2_r ^ pin_ref_r));

  // Timers wake only if not on system clock and source alive
  assign t16_wake = T16_MATCH & ~T16_SYSTEM_CLOCK_SOURCE_SRC & T16_SRC_ON;
  assign t8_wake  = T8_MATCH & ~T8_SYSTEM_CLOCK_SOURCE_SRC & T8_SRC_ON;
  assign cmp_wake = cmp_s_r[1] & COMPARATOR_CONTROL[`CMP_EN_BIT]
                    & COMPARATOR_SELECT[`CMP_WAKE_BIT];

  assign wake_evt = (state_r == DOWN) ? pin_wake
                  : (state_r == SAVE) ? (pin_wake | t16_wake | t8_wake | cmp_wake)
                  : 1'b0;

  assign fast_sel = MISC_CFG[`FAST_WAKE_BIT] & SLOW_BOOT;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      RUN: begin
        if (STOP_DOWN)
          state_nxt = DOWN;
        else if (STOP_SAVE)
          state_nxt = SAVE;
      end
      SAVE: begin
        if (wake_evt)
          state_nxt = WAKE;
      end
      DOWN: begin
        if (wake_evt)
          state_nxt = WAKE;
      end
      WAKE: begin
        if (tick_rise && wcnt_r == wtarget_r - 1'b1)
          state_nxt = RUN;
      end
      default: state_nxt = RUN;
    endcase
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r     <= RUN;
      from_down_r <= 1'b0;
      pin_ref_r   <= {PINS{1'b0}};
      wcnt_r      <= {`WAKE_CNT_W{1'b0}};
      wtarget_r   <= `WAKE_NORMAL_CYC;
    end else begin
      state_r <= state_nxt;
      if (state_r == RUN) begin
        pin_ref_r   <= pin_s2_r;
        from_down_r <= STOP_DOWN;
      end
      if (state_nxt == WAKE && state_r != WAKE) begin
        wcnt_r    <= {`WAKE_CNT_W{1'b0}};
        wtarget_r <= fast_sel ? `WAKE_FAST_CYC : `WAKE_NORMAL_CYC;
      end else if (state_r == WAKE && tick_rise) begin
        wcnt_r <= wcnt_r + 1'b1;
      end
    end
  end

  // Output gating; nothing here touches core or memory contents
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SYS_CLK_EN   <= 1'b1;
      FAST_OSC_EN  <= 1'b1;
      SLOW_OSC_EN  <= 1'b1;
      PROG_MEM_EN  <= 1'b1;
      T16_COUNT_EN <= 1'b1;
      T8_COUNT_EN  <= 1'b1;
      WDOG_EN      <= 1'b0;
      CORE_RESUME  <= 1'b0;
      POWER_STATE  <= RUN;
    end else begin
      POWER_STATE <= state_nxt;
      SYS_CLK_EN  <= (state_nxt == RUN);
      PROG_MEM_EN <= (state_nxt == RUN);
      // Power-down stops both; wake from it restarts on slow osc
      FAST_OSC_EN <= FAST_OSC_EN_CFG & ~(state_nxt == DOWN)
                     & ~(state_nxt == WAKE & from_down_r);
      SLOW_OSC_EN <= SLOW_OSC_EN_CFG & ~(state_nxt == DOWN)
                     | (state_nxt == WAKE);
      T16_COUNT_EN <= (state_nxt == RUN)
                      | ((state_nxt == SAVE) & ~T16_SYSTEM_CLOCK_SOURCE_SRC & T16_SRC_ON);
      T8_COUNT_EN  <= (state_nxt == RUN)
                      | ((state_nxt == SAVE) & ~T8_SYSTEM_CLOCK_SOURCE_SRC & T8_SRC_ON);
      WDOG_EN     <= CLOCK_MODE[`WDOG_EN_BIT] & SLOW_OSC_EN_CFG
                     & (state_nxt != DOWN);
      CORE_RESUME <= (state_r == WAKE) & (state_nxt == RUN);
    end
  end

endmodule // power_mode_wakeup_controller

// ==== tb/slow_osc_model.sv ====
/* Slow internal oscillator model for the wake-up bench.
   Assumes SLOW_OSC_EN from the controller gates it. */
`timescale 1ns/1ns
module slow_osc_model (
  input  wire SLOW_OSC_EN, // Oscillator enable
  output reg  TICK         // Slow clock, low while stopped
);
  initial TICK = 1'b0;
  always #14 TICK = SLOW_OSC_EN ? ~TICK : 1'b0;
endmodule // slow_osc_model

// ==== tb/pwr_mode_checker.sv ====
/* Port assertions for the power-mode controller.
   Assumes binding into every controller instance. */
`timescale 1ns/1ns
module pwr_mode_checker #(parameter PINS = 8) (
  input wire            CLK, RSTN, STOP_SAVE, STOP_DOWN, T16_SYSTEM_CLOCK_SOURCE_SRC, T16_SRC_ON,
  input wire            SYS_CLK_EN, FAST_OSC_EN, SLOW_OSC_EN, PROG_MEM_EN,
  input wire            T16_COUNT_EN, WDOG_EN, CORE_RESUME,
  input wire [PINS-1:0] PIN_DIG_EN,
  input wire [1:0]      POWER_STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence save_held; POWER_STATE == 2'h1 ##1 POWER_STATE == 2'h1; endsequence
  sequence wake_done; POWER_STATE == 2'h3 ##1 POWER_STATE == 2'h0; endsequence
  chk_save_entry: assert property (POWER_STATE == 2'h0 && STOP_SAVE && !STOP_DOWN
    |=> POWER_STATE == 2'h1) else $error("save entry missed");
  chk_down_entry: assert property (POWER_STATE == 2'h0 && STOP_DOWN
    |=> POWER_STATE == 2'h2) else $error("down entry missed");
  chk_sleep_gates: assert property (POWER_STATE inside {2'h1, 2'h2}
    |-> !SYS_CLK_EN && !PROG_MEM_EN) else $error("clock or memory on in sleep");
  chk_down_osc: assert property (POWER_STATE == 2'h2
    |-> !FAST_OSC_EN && !SLOW_OSC_EN) else $error("oscillator on in power-down");
  chk_save_osc: assert property (save_held
    |-> $stable(FAST_OSC_EN) && SLOW_OSC_EN) else $error("oscillator changed in save");
  chk_timer_gate: assert property (save_held |-> T16_COUNT_EN ==
    (!$past(T16_SYSTEM_CLOCK_SOURCE_SRC) && $past(T16_SRC_ON))) else $error("timer gate wrong");
  chk_down_hold: assert property (POWER_STATE == 2'h2 && PIN_DIG_EN == 0
    |=> POWER_STATE == 2'h2) else $error("woke from down without armed pin");
  chk_resume_pulse: assert property (wake_done
    |-> CORE_RESUME && SYS_CLK_EN && PROG_MEM_EN) else $error("resume incomplete");
  chk_resume_cause: assert property (CORE_RESUME
    |-> $past(POWER_STATE) == 2'h3) else $error("resume without wake");
  chk_wake_osc: assert property (POWER_STATE == 2'h3
    |-> SLOW_OSC_EN && !SYS_CLK_EN) else $error("wake delay gating wrong");
  chk_wdog_slow: assert property (!SLOW_OSC_EN |-> !WDOG_EN)
    else $error("watchdog on without slow oscillator");
endmodule // pwr_mode_checker
bind power_mode_wakeup_controller pwr_mode_checker #(.PINS(PINS)) chk (.*);

// ==== tb/power_mode_wakeup_controller_tb.sv ====
/* Random self-checking bench for the power-mode controller.
   Assumes the oscillator model and checker compile first. */
`timescale 1ns/1ns
module power_mode_wakeup_controller_tb;
  reg CLK = 0, RSTN = 0, STOP_SAVE = 0, STOP_DOWN = 0, SLOW_BOOT = 1, CMP_OUT_EVT = 0;
  reg FAST_OSC_EN_CFG = 1, SLOW_OSC_EN_CFG = 1, T16_MATCH = 0, T16_SYSTEM_CLOCK_SOURCE_SRC = 1;
  reg T16_SRC_ON = 1, T8_MATCH = 0, T8_SYSTEM_CLOCK_SOURCE_SRC = 0, T8_SRC_ON = 0;
  reg [7:0] CLOCK_MODE = 8'h02, COMPARATOR_CONTROL = 8'h80, COMPARATOR_SELECT = 8'h00;
  reg [7:0] MISC_CFG = 8'h20, PIN_IN = 8'h00, PIN_INPUT_MODE = 8'h00, PIN_DIG_EN = 8'h00;
  reg [31:0] r;
  wire SLOW_OSC_TICK, SYS_CLK_EN, FAST_OSC_EN, SLOW_OSC_EN, PROG_MEM_EN, T16_COUNT_EN;
  wire T8_COUNT_EN, WDOG_EN, CORE_RESUME;
  wire [1:0] POWER_STATE;
  integer mismatches = 0, tests_run = 0, seed = 59744, i, p, k;
  always #2 CLK = ~CLK;
  slow_osc_model osc (.SLOW_OSC_EN(SLOW_OSC_EN), .TICK(SLOW_OSC_TICK));
  power_mode_wakeup_controller #(.PINS(8)) dut (.*);
  function [11:0] wake_len(input fast, boot);
    wake_len = (fast && boot) ? 12'h020 : 12'h800;
  endfunction
  task automatic chk(input string nm, input logic [11:0] e, g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task print_verdict;
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wake_end(input [11:0] e);
    reg last;
    integer c;
    c = 0;
    k = 0;
    while (POWER_STATE !== 2'h3 && k < 20) begin @(negedge CLK); k = k + 1; end
    last = SLOW_OSC_TICK;
    while (POWER_STATE === 2'h3 && k < 20000) begin
      @(negedge CLK);
      k = k + 1;
      if (SLOW_OSC_TICK && !last) c = c + 1;
      last = SLOW_OSC_TICK;
    end
    chk("resume", 12'h001, {11'h000, CORE_RESUME});
    chk("ticks", e, (c + 1 == e) ? e : c[11:0]);
  endtask
  initial begin #200000; mismatches = mismatches + 1; print_verdict; end
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk("wdog", 12'h001, {11'h000, WDOG_EN});
    @(posedge CLK);
    SLOW_OSC_EN_CFG <= 1'b0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk("wdog_off", 12'h000, {11'h000, WDOG_EN});
    @(posedge CLK);
    SLOW_OSC_EN_CFG <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge CLK);
      r = $random(seed);
      p = r[30:28];
      CLOCK_MODE <= 8'h00;
      COMPARATOR_CONTROL <= (i % 4 == 1) ? 8'h00 : 8'h80;
      T16_MATCH <= 1'b0;
      CMP_OUT_EVT <= 1'b0;
      SLOW_BOOT <= (i != 0);
      MISC_CFG <= r[7:0] | 8'h20;
      {FAST_OSC_EN_CFG, T8_SYSTEM_CLOCK_SOURCE_SRC, T8_SRC_ON} <= r[10:8];
      PIN_IN <= r[23:16];
      PIN_INPUT_MODE <= (i % 2) ? r[31:24] : 8'h01 << p;
      PIN_DIG_EN <= (i % 2) ? 8'h00 : (8'h01 << p) | (8'h01 << ((p + 1) % 8)) | 8'h01;
      T16_SYSTEM_CLOCK_SOURCE_SRC <= ~i[0];
      COMPARATOR_SELECT <= {1'b0, i[0], 6'h00};
      repeat (4) @(posedge CLK);
      STOP_DOWN <= i[0];
      STOP_SAVE <= ~i[0];
      @(posedge CLK);
      {STOP_SAVE, STOP_DOWN} <= 2'b00;
      @(negedge CLK);
      chk("state", 12'h001 + i[0], POWER_STATE);
      chk("gates", {8'h00, i[0] ? 2'b00 : {r[10], 1'b1}, 2'b00},
          {FAST_OSC_EN, SLOW_OSC_EN, SYS_CLK_EN, PROG_MEM_EN});
      @(posedge CLK);
      T16_MATCH <= 1'b1;
      T8_MATCH <= i[0];
      CMP_OUT_EVT <= 1'b1;
      PIN_IN <= PIN_IN ^ (8'h01 << ((p + 1 - i % 2) % 8));
      repeat (40) @(posedge CLK);
      T16_MATCH <= 1'b0;
      T8_MATCH <= 1'b0;
      CMP_OUT_EVT <= 1'b0;
      @(negedge CLK);
      chk("held", 12'h001 + i[0], POWER_STATE);
      if (!i[0]) chk("count", {T8_SYSTEM_CLOCK_SOURCE_SRC, T8_SRC_ON} == 2'b01, T8_COUNT_EN);
      @(posedge CLK);
      case ((i % 2) ? 3 : (i / 2) % 3)
        0: PIN_IN <= PIN_IN ^ (8'h01 << p);
        1: begin T16_SYSTEM_CLOCK_SOURCE_SRC <= 1'b0; T16_MATCH <= 1'b1; end
        2: begin COMPARATOR_SELECT <= 8'h40; CMP_OUT_EVT <= 1'b1; end
        default: PIN_DIG_EN <= 8'h01 << p;
      endcase
      wake_end(wake_len(MISC_CFG[5], SLOW_BOOT));
    end
    print_verdict;
  end
endmodule // power_mode_wakeup_controller_tb
